// ---- pixel_burst_udp_framer_consts.vh ----
// constants for the two-link pixel burst framer with UDP output
// assumes a 40 MHz system clock and APB register access
`ifndef PIXEL_BURST_UDP_FRAMER_CONSTS_VH
`define PIXEL_BURST_UDP_FRAMER_CONSTS_VH
`define CLK_HZ 40000000
`define TP_RATE_MIN_HZ 5
`define TP_RATE_MAX_HZ 1200
`define TP_RATE_DEF_HZ 1000
`define BURST_DEPTH 32768
`define BURST_AW 15
`define PKT_WORDS 128
`define PR_SEED 15'h0001
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PERR0 8'h08
`define REG_PERR1 8'h0C
`define REG_TP_PERIOD 8'h10
`define REG_TAG_EL_LO 8'h14
`define REG_TAG_EL_HI 8'h18
`define REG_TAG_SHUT 8'h1C
`define REG_SERIAL 8'h20
`define REG_INT_STAT 8'h24
`define REG_INT_MASK 8'h28
// control bits
`define CTRL_DECODE 0
`define CTRL_TEST 1
`define CTRL_TIME_CLR 2
// interrupt bits
`define INT_BURST 0
`define INT_PERR 1
`define INT_SENT 2
// built-in network identity, arbitrary values
`define NET_DST_MAC 48'hFFFFFFFFFFFF
`define NET_SRC_MAC 48'h020000000001
`define NET_SRC_IP 32'hC0A80002
`define NET_DST_IP 32'hC0A80001
`define NET_SRC_PORT 16'h1000
`define NET_DST_PORT 16'h1001
`define HDR_WORDS 8
`endif

// ---- pixel_burst_udp_framer.v ----
// two-link DDR pixel capture, burst buffers and UDP framing onto a 64-bit stream
// assumes link pins are asynchronous and slow against the 40 MHz clock
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pixel_burst_udp_framer_consts.vh"

module link_capture #(
  parameter DEPTH = `BURST_DEPTH,
  parameter AW = `BURST_AW
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // link pins
  input wire i_lnk_clk,
  input wire [27:0] i_pixel_lane,
  input wire i_parity,
  input wire i_sob,
  // control
  input wire i_decode_on,
  input wire i_release,
  input wire [AW-1:0] i_rd_addr,
  // status and data
  output reg [59:0] o_rd_data,
  output reg o_done,
  output reg o_done_pulse,
  output reg o_perr_pulse,
  output reg [31:0] o_perr_cnt
);
  reg [59:0] mem [0:DEPTH-1];
  reg [2:0] ck_sync_r;
  reg [29:0] d_s1_r;
  reg [29:0] d_s2_r;
  reg [29:0] half_r;
  reg [AW-1:0] fill_r;
  reg active_r;
  wire ck_edge;
  wire ck_rise;
  wire perr_now;

  // gray-weighted counter code back to binary, per 14-bit group
  function [13:0] dec14;
    input [13:0] v;
    integer k;
    begin
      dec14[13] = v[13];
      for (k = 12; k >= 0; k = k - 1)
        dec14[k] = dec14[k+1] ^ v[k];
    end
  endfunction

  function [29:0] dec_half;
    input [29:0] h;
    input en;
    begin
      if (en)
        dec_half = {h[29:28], dec14(h[27:14]), dec14(h[13:0])};
      else
        dec_half = h;
    end
  endfunction

  // both edges of the forwarded clock are found after two flops; data is
  // delayed by the same two flops, so the sample lands mid-eye
  assign ck_edge = ck_sync_r[1] ^ ck_sync_r[2];
  assign ck_rise = ck_sync_r[1] & ~ck_sync_r[2];
  assign perr_now = ck_edge & (^{d_s2_r[28], d_s2_r[27:0]});

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      ck_sync_r <= 3'h0;
      d_s1_r <= 30'h0;
      d_s2_r <= 30'h0;
    end else begin
      ck_sync_r <= {ck_sync_r[1:0], i_lnk_clk};
      d_s1_r <= {i_sob, i_parity, i_pixel_lane};
      d_s2_r <= d_s1_r;
    end
  end

  always @(posedge i_clk) begin
    o_rd_data <= mem[i_rd_addr];
    if (active_r && ck_edge && !ck_rise)
      mem[fill_r] <= {dec_half(d_s2_r, i_decode_on), half_r};
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      half_r <= 30'h0;
      fill_r <= {AW{1'b0}};
      active_r <= 1'b0;
      o_done <= 1'b0;
      o_done_pulse <= 1'b0;
      o_perr_pulse <= 1'b0;
      o_perr_cnt <= 32'h0;
    end else begin
      o_done_pulse <= 1'b0;
      o_perr_pulse <= perr_now;
      if (perr_now)
        o_perr_cnt <= o_perr_cnt + 32'h1;
      if (i_release)
        o_done <= 1'b0;
      if (ck_rise) begin
        half_r <= dec_half(d_s2_r, i_decode_on);
        // a new burst is ignored while the previous one waits to be sent
        if (d_s2_r[29] && !o_done) begin
          active_r <= 1'b1;
          fill_r <= {AW{1'b0}};
        end
      end else if (ck_edge && active_r) begin
        if (fill_r == DEPTH - 1) begin
          active_r <= 1'b0;
          o_done <= 1'b1;
          o_done_pulse <= 1'b1;
        end
        fill_r <= fill_r + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // link_capture

module pixel_burst_udp_framer #(
  parameter DEPTH = `BURST_DEPTH,
  parameter AW = `BURST_AW,
  parameter PKT_WORDS = `PKT_WORDS,
  parameter [31:0] TP_PERIOD_DEF = `CLK_HZ / `TP_RATE_DEF_HZ
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // board link 0
  input wire i_lnk0_clk,
  input wire [27:0] i_lnk0_pixel_lane,
  input wire i_lnk0_parity,
  input wire i_lnk0_sob,
  // board link 1
  input wire i_lnk1_clk,
  input wire [27:0] i_lnk1_pixel_lane,
  input wire i_lnk1_parity,
  input wire i_lnk1_sob,
  // shutter and trigger pins
  input wire i_shutter,
  input wire i_trigger,
  // 64-bit stream toward the Ethernet subsystem
  output reg [63:0] o_tx_tdata,
  output reg o_tx_tvalid,
  output reg o_tx_tlast,
  input wire i_tx_tready,
  // interrupt
  output reg o_irq
);
  // udp header, 22 bytes of tags, then the payload words
  localparam [31:0] UDP_LEN_W = 32'h00000008 + 32'h00000016 + PKT_WORDS * 8;
  localparam [15:0] UDP_LEN = UDP_LEN_W[15:0];
  localparam [47:0] SRC_MAC = `NET_SRC_MAC;
  localparam [31:0] DST_IP = `NET_DST_IP;
  localparam [15:0] IP_LEN = 16'd20 + UDP_LEN;
  localparam [31:0] TP_MIN = `CLK_HZ / `TP_RATE_MAX_HZ;
  localparam [31:0] TP_MAX = `CLK_HZ / `TP_RATE_MIN_HZ;
  localparam S_IDLE = 3'd0;
  localparam S_HDR = 3'd1;
  localparam S_PAYRD = 3'd2;
  localparam S_PAY = 3'd3;
  localparam S_DONE = 3'd4;

  reg [2:0] st_r;
  reg [1:0] src_r;
  reg [2:0] hdr_idx_r;
  reg [AW-1:0] word_r;
  reg [14:0] pr_r;
  reg release_r;
  reg decode_on_r;
  reg test_en_r;
  reg time_clr_r;
  reg [31:0] tp_period_r;
  reg [31:0] tp_cnt_r;
  reg tp_tick_r;
  reg [2:0] int_stat_r;
  reg [2:0] int_mask_r;
  reg [1:0] sh_sync_r;
  reg [1:0] tr_sync_r;
  reg sh_d_r;
  reg tr_d_r;
  reg [47:0] elapsed_r;
  reg [31:0] sht_time_r;
  reg [47:0] tag_el_r;
  reg [31:0] tag_sh_r;
  reg [31:0] serial_r;
  reg sent_pulse_r;
  wire [59:0] rd0;
  wire [59:0] rd1;
  wire done0;
  wire done1;
  wire dp0;
  wire dp1;
  wire pe0;
  wire pe1;
  wire [31:0] perr0;
  wire [31:0] perr1;
  wire sh_rise;
  wire tr_rise;
  wire accept;
  wire can_load;
  wire apb_acc;
  wire [2:0] int_set;
  wire [31:0] pkt_quot;
  wire [15:0] pkt_idx;
  reg [63:0] hdr_word;
  reg [63:0] pay_word;

  link_capture #(.DEPTH(DEPTH), .AW(AW)) u_lnk0 (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_lnk_clk(i_lnk0_clk),
    .i_pixel_lane(i_lnk0_pixel_lane), .i_parity(i_lnk0_parity), .i_sob(i_lnk0_sob),
    .i_decode_on(decode_on_r), .i_release(release_r), .i_rd_addr(word_r),
    .o_rd_data(rd0), .o_done(done0), .o_done_pulse(dp0), .o_perr_pulse(pe0),
    .o_perr_cnt(perr0)
  );
  link_capture #(.DEPTH(DEPTH), .AW(AW)) u_lnk1 (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_lnk_clk(i_lnk1_clk),
    .i_pixel_lane(i_lnk1_pixel_lane), .i_parity(i_lnk1_parity), .i_sob(i_lnk1_sob),
    .i_decode_on(decode_on_r), .i_release(release_r), .i_rd_addr(word_r),
    .o_rd_data(rd1), .o_done(done1), .o_done_pulse(dp1), .o_perr_pulse(pe1),
    .o_perr_cnt(perr1)
  );

  assign sh_rise = sh_sync_r[1] & ~sh_d_r;
  assign tr_rise = tr_sync_r[1] & ~tr_d_r;
  assign accept = o_tx_tvalid & i_tx_tready;
  assign can_load = ~o_tx_tvalid | i_tx_tready;
  assign apb_acc = i_psel & i_penable & ~o_pready;
  assign pkt_quot = {{(32-AW){1'b0}}, word_r} / PKT_WORDS;
  assign pkt_idx = pkt_quot[15:0];
  assign int_set = {sent_pulse_r, pe0 | pe1, (dp0 & done1) | (dp1 & done0)};

  // header: Ethernet, IPv4 and UDP, then source, serial and time tags
  always @* begin
    case (hdr_idx_r)
      3'd0: hdr_word = {`NET_DST_MAC, SRC_MAC[47:32]};
      3'd1: hdr_word = {SRC_MAC[31:0], 16'h0800, 16'h4500};
      3'd2: hdr_word = {IP_LEN, pkt_idx, 16'h4000, 16'h4011};
      3'd3: hdr_word = {16'h0000, `NET_SRC_IP, DST_IP[31:16]};
      3'd4: hdr_word = {DST_IP[15:0], `NET_SRC_PORT, `NET_DST_PORT, UDP_LEN};
      3'd5: hdr_word = {16'h0000, 14'h0000, src_r, serial_r};
      3'd6: hdr_word = {tag_el_r, pkt_idx};
      default: hdr_word = {tag_sh_r, 32'h0000_0000};
    endcase
  end

  // payload: board word, or test pattern with fixed marker bits
  always @* begin
    if (src_r == 2'd2)
      pay_word = {1'b1, pr_r, 1'b0, pr_r, 1'b0, pr_r, 1'b1, pr_r};
    else if (src_r == 2'd1)
      pay_word = {4'h0, rd1};
    else
      pay_word = {4'h0, rd0};
  end

  // packet sequencer; one source is emptied completely before the next
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r <= S_IDLE;
      src_r <= 2'd0;
      hdr_idx_r <= 3'd0;
      word_r <= {AW{1'b0}};
      pr_r <= `PR_SEED;
      release_r <= 1'b0;
      sent_pulse_r <= 1'b0;
      o_tx_tdata <= 64'h0;
      o_tx_tvalid <= 1'b0;
      o_tx_tlast <= 1'b0;
    end else begin
      release_r <= 1'b0;
      sent_pulse_r <= 1'b0;
      if (accept) begin
        o_tx_tvalid <= 1'b0;
        o_tx_tlast <= 1'b0;
      end
      case (st_r)
        S_IDLE: begin
          word_r <= {AW{1'b0}};
          hdr_idx_r <= 3'd0;
          pr_r <= `PR_SEED;
          if (test_en_r && tp_tick_r) begin
            src_r <= 2'd2;
            st_r <= S_HDR;
          // done flags fall one cycle after release; without the gate the
          // buffers just sent would be sent a second time
          end else if (!test_en_r && done0 && done1 && !release_r) begin
            src_r <= 2'd0;
            st_r <= S_HDR;
          end
        end
        S_HDR: begin
          if (can_load) begin
            o_tx_tdata <= hdr_word;
            o_tx_tvalid <= 1'b1;
            hdr_idx_r <= hdr_idx_r + 3'd1;
            if (hdr_idx_r == `HDR_WORDS - 1)
              st_r <= S_PAYRD;
          end
        end
        S_PAYRD: st_r <= S_PAY;
        S_PAY: begin
          if (can_load) begin
            o_tx_tdata <= pay_word;
            o_tx_tvalid <= 1'b1;
            o_tx_tlast <= (word_r % PKT_WORDS) == PKT_WORDS - 1;
            word_r <= word_r + {{(AW-1){1'b0}}, 1'b1};
            // last state is shown twice to make the sequence one longer
            if (word_r < DEPTH - 2)
              pr_r <= {pr_r[13:0], pr_r[14] ^ pr_r[13]};
            if (word_r == DEPTH - 1)
              st_r <= S_DONE;
            else if ((word_r % PKT_WORDS) == PKT_WORDS - 1)
              st_r <= S_HDR;
            else
              st_r <= S_PAYRD;
          end
        end
        S_DONE: begin
          if (!o_tx_tvalid || accept) begin
            word_r <= {AW{1'b0}};
            hdr_idx_r <= 3'd0;
            if (src_r == 2'd0) begin
              src_r <= 2'd1;
              st_r <= S_HDR;
            end else begin
              release_r <= (src_r == 2'd1);
              sent_pulse_r <= 1'b1;
              st_r <= S_IDLE;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // test pattern repeat timer; ticks while busy are dropped
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      tp_cnt_r <= 32'h0;
      tp_tick_r <= 1'b0;
    end else begin
      tp_tick_r <= 1'b0;
      if (tp_cnt_r >= tp_period_r - 32'h1) begin
        tp_cnt_r <= 32'h0;
        tp_tick_r <= 1'b1;
      end else begin
        tp_cnt_r <= tp_cnt_r + 32'h1;
      end
    end
  end

  // shutter time tags and serial number
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      sh_sync_r <= 2'h0;
      tr_sync_r <= 2'h0;
      sh_d_r <= 1'b0;
      tr_d_r <= 1'b0;
      elapsed_r <= 48'h0;
      sht_time_r <= 32'h0;
      tag_el_r <= 48'h0;
      tag_sh_r <= 32'h0;
      serial_r <= 32'h0;
    end else begin
      sh_sync_r <= {sh_sync_r[0], i_shutter};
      tr_sync_r <= {tr_sync_r[0], i_trigger};
      sh_d_r <= sh_sync_r[1];
      tr_d_r <= tr_sync_r[1];
      if (time_clr_r)
        elapsed_r <= 48'h0;
      else
        elapsed_r <= elapsed_r + 48'h1;
      if (tr_rise)
        sht_time_r <= 32'h0;
      else
        sht_time_r <= sht_time_r + 32'h1;
      if (sh_rise) begin
        tag_el_r <= elapsed_r;
        tag_sh_r <= sht_time_r;
      end
      if (tr_rise)
        serial_r <= 32'h0;
      else if (sh_rise)
        serial_r <= serial_r + 32'h1;
    end
  end

  // APB slave, one wait state; interrupt status set beats clear
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      decode_on_r <= 1'b0;
      test_en_r <= 1'b0;
      time_clr_r <= 1'b0;
      tp_period_r <= TP_PERIOD_DEF;
      int_stat_r <= 3'h0;
      int_mask_r <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      o_pready <= apb_acc;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
      time_clr_r <= 1'b0;
      o_irq <= |(int_stat_r & int_mask_r);
      int_stat_r <= int_stat_r | int_set;
      if (apb_acc && i_pwrite) begin
        if (i_paddr == `REG_CTRL) begin
          decode_on_r <= i_pwdata[`CTRL_DECODE];
          test_en_r <= i_pwdata[`CTRL_TEST];
          time_clr_r <= i_pwdata[`CTRL_TIME_CLR];
        end else if (i_paddr == `REG_TP_PERIOD) begin
          if (i_pwdata < TP_MIN)
            tp_period_r <= TP_MIN;
          else if (i_pwdata > TP_MAX)
            tp_period_r <= TP_MAX;
          else
            tp_period_r <= i_pwdata;
        end else if (i_paddr == `REG_INT_STAT) begin
          int_stat_r <= (int_stat_r & ~i_pwdata[2:0]) | int_set;
        end else if (i_paddr == `REG_INT_MASK) begin
          int_mask_r <= i_pwdata[2:0];
        end else if (i_paddr != `REG_STATUS && i_paddr != `REG_PERR0 &&
                     i_paddr != `REG_PERR1 && i_paddr != `REG_TAG_EL_LO &&
                     i_paddr != `REG_TAG_EL_HI && i_paddr != `REG_TAG_SHUT &&
                     i_paddr != `REG_SERIAL) begin
          o_pslverr <= 1'b1;
        end
      end else if (apb_acc) begin
        if (i_paddr == `REG_CTRL)
          o_prdata <= {29'h0, 1'b0, test_en_r, decode_on_r};
        else if (i_paddr == `REG_STATUS)
          o_prdata <= {26'h0, st_r, st_r != S_IDLE, done1, done0};
        else if (i_paddr == `REG_PERR0)
          o_prdata <= perr0;
        else if (i_paddr == `REG_PERR1)
          o_prdata <= perr1;
        else if (i_paddr == `REG_TP_PERIOD)
          o_prdata <= tp_period_r;
        else if (i_paddr == `REG_TAG_EL_LO)
          o_prdata <= tag_el_r[31:0];
        else if (i_paddr == `REG_TAG_EL_HI)
          o_prdata <= {16'h0, tag_el_r[47:32]};
        else if (i_paddr == `REG_TAG_SHUT)
          o_prdata <= tag_sh_r;
        else if (i_paddr == `REG_SERIAL)
          o_prdata <= serial_r;
        else if (i_paddr == `REG_INT_STAT)
          o_prdata <= {29'h0, int_stat_r};
        else if (i_paddr == `REG_INT_MASK)
          o_prdata <= {29'h0, int_mask_r};
        else
          o_pslverr <= 1'b1;
      end
    end
  end
endmodule // pixel_burst_udp_framer
`default_nettype wire

// ---- pixel_burst_udp_framer_chk.sv ----
// assertion checker for the framer's APB and stream ports
// bound to the top module; sees nothing but its ports
`timescale 1ns/100ps
`default_nettype none
`include "pixel_burst_udp_framer_consts.vh"
module pixel_burst_udp_framer_chk #(
  parameter PKT_WORDS = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // register bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // stream
  input wire logic [63:0] o_tx_tdata,
  input wire logic o_tx_tvalid,
  input wire logic o_tx_tlast,
  input wire logic i_tx_tready
);
  localparam int LAST_BEAT = `HDR_WORDS + PKT_WORDS - 1;
  logic [15:0] beat_r;
  logic [15:0] beat_nxt;
  wire logic acc = o_tx_tvalid && i_tx_tready;
  // beat index inside the current packet
  always_comb beat_nxt = !acc ? beat_r : (o_tx_tlast ? 16'h0000 : beat_r + 16'h0001);
  always_ff @(posedge i_clk) beat_r <= !i_reset_n ? 16'h0000 : beat_nxt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  chk_ready_timely: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("access phase not answered");
  chk_ready_cause: assert property (o_pready |-> $past(i_psel) && $past(i_penable))
    else $error("pready without access");
  chk_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr outside answer");
  chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  chk_err_read_zero: assert property (o_pslverr |-> o_prdata == 32'h0)
    else $error("refused read returned data");
  chk_stream_hold: assert property (
    o_tx_tvalid && !i_tx_tready |=>
      o_tx_tvalid && $stable(o_tx_tdata) && $stable(o_tx_tlast))
    else $error("stream word changed while stalled");
  chk_pkt_length: assert property (acc && o_tx_tlast |-> beat_r == LAST_BEAT)
    else $error("packet length wrong");
  chk_last_at_end: assert property (acc && beat_r == LAST_BEAT |-> o_tx_tlast)
    else $error("packet end not marked");
endmodule // pixel_burst_udp_framer_chk
bind pixel_burst_udp_framer pixel_burst_udp_framer_chk #(.PKT_WORDS(PKT_WORDS)) u_chk (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_tx_tdata(o_tx_tdata),
  .o_tx_tvalid(o_tx_tvalid),
  .o_tx_tlast(o_tx_tlast),
  .i_tx_tready(i_tx_tready)
);
`default_nettype wire

// ---- link_source_model.sv ----
// behavioural model of one readout board link, DDR with forwarded clock
// the clock idles low between bursts; edges centred in each half word
`timescale 1ns/100ps
`default_nettype none
module link_source_model (
  // link pins
  output logic o_lnk_clk,
  output logic [27:0] o_pixel_lane,
  output logic o_parity,
  output logic o_sob
);
  function automatic logic [27:0] lane_of(input logic id, input int k, input logic h);
    return {h, id, 18'h00000, k[7:0]};
  endfunction
  initial begin
    o_lnk_clk = 1'b0;
    o_pixel_lane = 28'h0000000;
    o_parity = 1'b0;
    o_sob = 1'b0;
  end
  // bad: word whose rising half carries wrong parity, -1 for none
  task automatic send_burst(input logic id, input int words, input int bad);
    for (int k = 0; k < words; k++) begin
      for (int h = 0; h < 2; h++) begin
        o_pixel_lane = lane_of(id, k, h[0]);
        o_parity = ^o_pixel_lane ^ (k == bad && h == 0);
        o_sob = (k == 0);
        #50;
        o_lnk_clk = (h == 0);
        #50;
      end
    end
    // released lines show the inverse, never a stale copy
    o_pixel_lane = ~o_pixel_lane;
    o_parity = ~o_parity;
    o_sob = ~o_sob;
  endtask
endmodule // link_source_model
`default_nettype wire

// ---- pixel_burst_udp_framer_tb.sv ----
// self-checking bench: APB master, two link models, stream sink
// shrinks buffer depth and packet size to keep the run short
`timescale 1ns/100ps
`default_nettype none
`include "pixel_burst_udp_framer_consts.vh"
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("BAD at %0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end
module pixel_burst_udp_framer_tb;
  localparam int DEPTH = 64;
  localparam int PKT = 8;
  localparam int NPK = DEPTH / PKT;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_shutter = 1'b0;
  logic i_trigger = 1'b0;
  logic i_tx_tready = 1'b0;
  logic stall = 1'b0;
  wire logic [31:0] o_prdata;
  wire logic o_pready;
  wire logic o_pslverr;
  wire logic [63:0] o_tx_tdata;
  wire logic o_tx_tvalid;
  wire logic o_tx_tlast;
  wire logic o_irq;
  wire logic [1:0] lclk;
  wire logic [1:0] lpar;
  wire logic [1:0] lsob;
  wire logic [27:0] lane0;
  wire logic [27:0] lane1;
  logic [64:0] rx_q[$];
  logic [31:0] rd_v;
  logic err_v;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  pixel_burst_udp_framer #(.DEPTH(DEPTH), .AW(6), .PKT_WORDS(PKT), .TP_PERIOD_DEF(2000)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_lnk0_clk(lclk[0]), .i_lnk0_pixel_lane(lane0),
    .i_lnk0_parity(lpar[0]), .i_lnk0_sob(lsob[0]),
    .i_lnk1_clk(lclk[1]), .i_lnk1_pixel_lane(lane1),
    .i_lnk1_parity(lpar[1]), .i_lnk1_sob(lsob[1]),
    .i_shutter(i_shutter), .i_trigger(i_trigger),
    .o_tx_tdata(o_tx_tdata), .o_tx_tvalid(o_tx_tvalid),
    .o_tx_tlast(o_tx_tlast), .i_tx_tready(i_tx_tready), .o_irq(o_irq)
  );
  link_source_model u_src0 (.o_lnk_clk(lclk[0]), .o_pixel_lane(lane0),
    .o_parity(lpar[0]), .o_sob(lsob[0]));
  link_source_model u_src1 (.o_lnk_clk(lclk[1]), .o_pixel_lane(lane1),
    .o_parity(lpar[1]), .o_sob(lsob[1]));

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (o_tx_tvalid === 1'b1 && i_tx_tready === 1'b1) rx_q.push_back({o_tx_tlast, o_tx_tdata});
    i_tx_tready <= stall ? ~i_tx_tready : 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge i_clk);
    end
    rd_v = o_prdata;
    err_v = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    `CHK(n < 20, 1'b1)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rd_v, e)
    `CHK(err_v, ee)
  endtask
  task automatic pulse(input logic trig);
    @(posedge i_clk);
    if (trig) i_trigger <= 1'b1;
    else i_shutter <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_trigger <= 1'b0;
    i_shutter <= 1'b0;
  endtask
  task automatic wait_q(input int n);
    int t;
    t = 0;
    while (rx_q.size() < n && t < 5000) begin
      t++;
      @(posedge i_clk);
    end
    `CHK(rx_q.size() >= n, 1'b1)
  endtask
  function automatic logic [13:0] g2b(input logic [13:0] g);
    for (int i = 12; i >= 0; i--) g[i] = g[i + 1] ^ g[i];
    return g;
  endfunction
  function automatic logic [27:0] dq(input logic [27:0] l, input logic d);
    return d ? {g2b(l[27:14]), g2b(l[13:0])} : l;
  endfunction
  function automatic logic [63:0] exp_word(input logic id, input int k, input int bad,
                                            input logic dec);
    logic [27:0] lr;
    logic [27:0] lf;
    logic s;
    lr = u_src0.lane_of(id, k, 1'b0);
    lf = u_src0.lane_of(id, k, 1'b1);
    s = (k == 0);
    return {4'h0, s, ^lf, dq(lf, dec), s, ^lr ^ (k == bad), dq(lr, dec)};
  endfunction

  task automatic check_regs();
    rd_chk(`REG_CTRL, 32'h0, 1'b0);
    rd_chk(`REG_INT_MASK, 32'h0, 1'b0);
    rd_chk(`REG_PERR0, 32'h0, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    apb(1'b1, `REG_STATUS, 32'hFFFFFFFF);
    rd_chk(`REG_STATUS, 32'h0, 1'b0);
  endtask
  task automatic check_tags();
    pulse(1'b1);
    repeat (100) @(posedge i_clk);
    pulse(1'b0);
    apb(1'b0, `REG_TAG_SHUT, 32'h0);
    `CHK(rd_v >= 32'h64 && rd_v <= 32'h6E, 1'b1)
    rd_chk(`REG_SERIAL, 32'h1, 1'b0);
    pulse(1'b0);
    rd_chk(`REG_SERIAL, 32'h2, 1'b0);
    pulse(1'b1);
    rd_chk(`REG_SERIAL, 32'h0, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h4);
    repeat (200) @(posedge i_clk);
    pulse(1'b0);
    apb(1'b0, `REG_TAG_EL_LO, 32'h0);
    `CHK(rd_v >= 32'hC8 && rd_v <= 32'hD7, 1'b1)
    rd_chk(`REG_TAG_EL_HI, 32'h0, 1'b0);
  endtask
  task automatic run_burst(input logic dec, input int bad);
    logic [64:0] w;
    rx_q.delete();
    apb(1'b1, `REG_CTRL, {31'h0, dec});
    fork
      u_src0.send_burst(1'b0, DEPTH, -1);
      begin
        #37;
        u_src1.send_burst(1'b1, DEPTH, bad);
      end
    join
    wait_q(2 * NPK * 16);
    for (int id = 0; id < 2; id++) for (int p = 0; p < NPK; p++) for (int b = 0; b < 16; b++) begin
      w = rx_q.pop_front();
      if (b == 5) `CHK(w[33:32], id[1:0])
      if (b == 6) `CHK(w[15:0], p[15:0])
      if (b >= 8) `CHK(w[63:0], exp_word(id[0], p * PKT + b - 8, id ? bad : -1, dec))
      `CHK(w[64], b == 15)
    end
    repeat (40) @(posedge i_clk);
    `CHK(rx_q.size() == 0, 1'b1)
  endtask
  task automatic check_irq();
    rd_chk(`REG_PERR1, 32'h1, 1'b0);
    rd_chk(`REG_INT_STAT, 32'h7, 1'b0);
    `CHK(o_irq, 1'b0)
    apb(1'b1, `REG_INT_MASK, 32'h2);
    repeat (2) @(posedge i_clk);
    `CHK(o_irq, 1'b1)
    apb(1'b1, `REG_INT_STAT, 32'h2);
    repeat (2) @(posedge i_clk);
    `CHK(o_irq, 1'b0)
    rd_chk(`REG_INT_STAT, 32'h5, 1'b0);
    apb(1'b1, `REG_INT_STAT, 32'h5);
  endtask
  task automatic check_test();
    logic [64:0] w;
    logic [63:0] prev;
    logic [14:0] pr;
    prev = 64'h0;
    pr = `PR_SEED;
    rx_q.delete();
    apb(1'b1, `REG_CTRL, 32'h2);
    wait_q(NPK * 16);
    apb(1'b1, `REG_CTRL, 32'h0);
    for (int p = 0; p < NPK; p++) for (int b = 0; b < 16; b++) begin
      w = rx_q.pop_front();
      if (b == 5) `CHK(w[33:32], 2'h2)
      if (p == 0 && b == 8)
        `CHK(w[63:0], {1'b1, 15'h0001, 1'b0, 15'h0001, 1'b0, 15'h0001, 1'b1, 15'h0001})
      if (p == NPK - 1 && b == 15) `CHK(w[63:0], prev)
      if (b >= 8) begin
        `CHK(w[63:0], {1'b1, pr, 1'b0, pr, 1'b0, pr, 1'b1, pr})
        if (p * PKT + b - 8 < DEPTH - 2) pr = {pr[13:0], pr[14] ^ pr[13]};
      end
      prev = w[63:0];
    end
  endtask
  task automatic check_clamp();
    rd_chk(`REG_TP_PERIOD, 32'h000007D0, 1'b0);
    apb(1'b1, `REG_TP_PERIOD, 32'h1);
    rd_chk(`REG_TP_PERIOD, 32'h00008235, 1'b0);
    apb(1'b1, `REG_TP_PERIOD, 32'hFFFFFFFF);
    rd_chk(`REG_TP_PERIOD, 32'h007A1200, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    check_regs();
    check_tags();
    stall <= 1'b1;
    run_burst(1'b0, 5);
    check_irq();
    stall <= 1'b0;
    run_burst(1'b1, -1);
    rd_chk(`REG_PERR1, 32'h1, 1'b0);
    check_test();
    check_clamp();
    report_and_stop();
  end
endmodule // pixel_burst_udp_framer_tb
`default_nettype wire
